/* logic/ebt_pkg.sv */
package ebt_pkg;
    // Register word indices; printed offsets 0x25/0x26 are not multiples of four,
    // so they are indices and the byte address is four times the index
    localparam logic [7:0] IDX_CTRL_B     = 8'h25;
    localparam logic [7:0] IDX_COUNT      = 8'h26;
    localparam logic [7:0] IDX_CMP_A      = 8'h27;
    localparam logic [7:0] IDX_CMP_B      = 8'h28;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'h2E;
    localparam logic [7:0] IDX_IRQ_FLAGS  = 8'h15;
    localparam logic [7:0] IDX_CTRL_A     = 8'h24;
    localparam logic [7:0] IDX_IRQ_ACK    = 8'h30;

    localparam int CTRL_B_FORCE_A  = 7;
    localparam int CTRL_B_FORCE_B  = 6;
    localparam int CTRL_B_WAVE2    = 3;
    localparam int IRQ_BIT_CMP_B   = 2;
    localparam int IRQ_BIT_CMP_A   = 1;
    localparam int IRQ_BIT_OVF     = 0;
    localparam int CTRL_A_MODE_A_LO = 6;
    localparam int CTRL_A_MODE_B_LO = 4;

    localparam logic [7:0] RESET_BYTE  = 8'h00;
    localparam logic [7:0] COUNT_MAX   = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;

    localparam int DIV_8    = 8;
    localparam int DIV_64   = 64;
    localparam int DIV_256  = 256;
    localparam int DIV_1024 = 1024;
    localparam int PRESCALE_WIDTH = 10;

    typedef enum logic [2:0]
    {
        CLK_STOP   = 3'b000,
        CLK_DIV1   = 3'b001,
        CLK_DIV8   = 3'b010,
        CLK_DIV64  = 3'b011,
        CLK_DIV256 = 3'b100,
        CLK_DIV1K  = 3'b101,
        CLK_EXT_FALL = 3'b110,
        CLK_EXT_RISE = 3'b111
    } ebt_clk_sel_t;

    typedef enum logic [2:0]
    {
        WM_NORMAL    = 3'b000,
        WM_PC_FF     = 3'b001,
        WM_CTC       = 3'b010,
        WM_FAST_FF   = 3'b011,
        WM_RSVD4     = 3'b100,
        WM_PC_OCRA   = 3'b101,
        WM_RSVD6     = 3'b110,
        WM_FAST_OCRA = 3'b111
    } ebt_wave_mode_t;
endpackage

/* logic/ebt_timer.sv */
`timescale 1ns/1ps
// Summary of operation
// R1: Force strobe applies compare action, non-PWM only
// R2: Forced compare sets no flag, no clear
// R3: Force strobe bits always read zero
// R4: Software writes force bits zero in PWM
// R5: Clock select picks stop or prescaled clock
// R6: Select 110/111 count external pin falling/rising
// R7: External pin counts even when driven out
// R8: Counter register readable, writable, resets zero
// R9: Counter write blocks next tick's compare
// R10: Compare registers continuously matched against counter
// R11: Enable bits 2..0 gate flags with global
// R12: Flag bit 2 compare B, bit 1 A
// R13: Overflow flag bit 0 set at overflow
// R14: Vector execution clears its flag
// R15: Write one clears flag, zero keeps
// R16: Reserved bits read zero
// R17: Bottom value is 0x00
// R18: Wave mode field picks mode and top
// R19: Overflow at MAX, BOTTOM or TOP per mode
// R20: Non-PWM compare output: off, toggle, clear, set
// R21: Normal mode wraps 0xFF to 0x00, flags overflow
module ebt_timer
    import ebt_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        external_count_pin,
    input  wire logic        global_irq_enable,
    input  wire logic [2:0]  vector_ack,
    output logic             compare_out_pin_a,
    output logic             compare_out_pin_b,
    output logic             compare_out_en_a,
    output logic             compare_out_en_b,
    output logic [2:0]       irq_request
);
    logic [7:0]  timer_control_b;
    logic [7:0]  timer_control_a;
    logic [7:0]  timer_count_value;
    logic [7:0]  compare_value_a;
    logic [7:0]  compare_value_b;
    logic [2:0]  timer_irq_enable;
    logic [2:0]  timer_irq_flags;
    logic        count_down;
    logic        block_match;
    logic [PRESCALE_WIDTH-1:0] prescale;
    logic        pin_meta;
    logic        pin_sync;
    logic        pin_prev;
    logic        tick;
    logic        wr_pend;
    logic [7:0]  wr_idx;
    logic        rd_err;
    logic        bus_wr;
    logic        bus_rd;
    logic [7:0]  bus_idx;
    logic [7:0]  wbyte;
    logic        wr_ctrl_b;
    logic        wr_count;
    logic        force_a;
    logic        force_b;
    logic [2:0]  clock_source_select;
    logic [2:0]  wave_mode_field;
    logic [1:0]  compare_out_mode_a;
    logic [1:0]  compare_out_mode_b;
    logic        pwm_mode;
    logic [7:0]  top_value;
    logic        match_a;
    logic        match_b;
    logic        at_top;
    logic        ovf_event;
    logic [7:0]  next_count;
    logic        next_dir;
    logic [2:0]  flag_set;
    logic [2:0]  flag_clr;
    logic [2:0]  flag_wr_clr;

    assign clock_source_select = timer_control_b[2:0];
    assign wave_mode_field = {timer_control_b[CTRL_B_WAVE2], timer_control_a[1:0]};
    assign compare_out_mode_a = timer_control_a[CTRL_A_MODE_A_LO +: 2];
    assign compare_out_mode_b = timer_control_a[CTRL_A_MODE_B_LO +: 2];
    assign compare_out_en_a = (compare_out_mode_a != 2'b00);
    assign compare_out_en_b = (compare_out_mode_b != 2'b00);

    // AHB-Lite slave: zero wait states, always OKAY
    assign bus_idx   = haddr[9:2];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign bus_wr    = hsel && hready && htrans[1] && hwrite;
    assign bus_rd    = hsel && hready && htrans[1] && !hwrite;
    assign wbyte     = hwdata[7:0];
    assign wr_ctrl_b = wr_pend && (wr_idx == IDX_CTRL_B);
    assign wr_count  = wr_pend && (wr_idx == IDX_COUNT);
    assign force_a   = wr_ctrl_b && wbyte[CTRL_B_FORCE_A] && !pwm_mode;  // [R1]
    assign force_b   = wr_ctrl_b && wbyte[CTRL_B_FORCE_B] && !pwm_mode;  // [R1]

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_idx  <= RESET_BYTE;
        end
        else
        begin
            wr_pend <= bus_wr;
            wr_idx  <= bus_idx;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
            rd_err <= 1'b0;
        end
        else if (bus_rd)
        begin
            rd_err <= 1'b0;
            case (bus_idx)
                IDX_CTRL_B:     hrdata <= {24'h00_0000, 4'h0, timer_control_b[3:0]};  // [R3] [R16]
                IDX_CTRL_A:     hrdata <= {24'h00_0000, timer_control_a};
                IDX_COUNT:      hrdata <= {24'h00_0000, timer_count_value};  // [R8]
                IDX_CMP_A:      hrdata <= {24'h00_0000, compare_value_a};
                IDX_CMP_B:      hrdata <= {24'h00_0000, compare_value_b};
                IDX_IRQ_ENABLE: hrdata <= {24'h00_0000, 5'h00, timer_irq_enable};  // [R16]
                IDX_IRQ_FLAGS:  hrdata <= {24'h00_0000, 5'h00, timer_irq_flags};   // [R16]
                default:        hrdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            timer_control_a  <= RESET_BYTE;
            timer_control_b  <= RESET_BYTE;
            compare_value_a  <= RESET_BYTE;
            compare_value_b  <= RESET_BYTE;
            timer_irq_enable <= 3'b000;
        end
        else if (wr_pend)
        begin
            case (wr_idx)
                IDX_CTRL_A:     timer_control_a <= {wbyte[7:4], 2'b00, wbyte[1:0]};
                IDX_CTRL_B:     timer_control_b <= {4'h0, wbyte[3:0]};  // [R3] [R16]
                IDX_CMP_A:      compare_value_a <= wbyte;
                IDX_CMP_B:      compare_value_b <= wbyte;
                IDX_IRQ_ENABLE: timer_irq_enable <= wbyte[2:0];  // [R11]
                default:        timer_irq_enable <= timer_irq_enable;
            endcase
        end
    end

    // Pin synchroniser then edge detector
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            pin_prev <= 1'b0;
        end
        else
        begin
            pin_meta <= external_count_pin;  // [R7]
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            prescale <= '0;
        else
            prescale <= prescale + 1'b1;
    end

    always_comb
    begin
        case (clock_source_select)  // [R5] [R6]
            CLK_STOP:     tick = 1'b0;
            CLK_DIV1:     tick = 1'b1;
            CLK_DIV8:     tick = (prescale[2:0] == 3'(DIV_8 - 1));
            CLK_DIV64:    tick = (prescale[5:0] == 6'(DIV_64 - 1));
            CLK_DIV256:   tick = (prescale[7:0] == 8'(DIV_256 - 1));
            CLK_DIV1K:    tick = (prescale == 10'(DIV_1024 - 1));
            CLK_EXT_FALL: tick = pin_prev && !pin_sync;
            CLK_EXT_RISE: tick = !pin_prev && pin_sync;
            default:      tick = 1'b0;
        endcase
    end

    always_comb
    begin
        pwm_mode  = 1'b0;
        top_value = COUNT_MAX;
        case (wave_mode_field)  // [R18]
            WM_NORMAL:    top_value = COUNT_MAX;
            WM_PC_FF:     pwm_mode = 1'b1;
            WM_CTC:       top_value = compare_value_a;
            WM_FAST_FF:   pwm_mode = 1'b1;
            WM_PC_OCRA:
            begin
                pwm_mode  = 1'b1;
                top_value = compare_value_a;
            end
            WM_FAST_OCRA:
            begin
                pwm_mode  = 1'b1;
                top_value = compare_value_a;
            end
            default:      top_value = COUNT_MAX;
        endcase
    end

    assign match_a = tick && !block_match && (timer_count_value == compare_value_a);  // [R10] [R9]
    assign match_b = tick && !block_match && (timer_count_value == compare_value_b);  // [R10] [R9]
    assign at_top  = (timer_count_value == top_value);

    always_comb
    begin
        next_count = timer_count_value;
        next_dir   = count_down;
        ovf_event  = 1'b0;
        case (wave_mode_field)
            WM_PC_FF, WM_PC_OCRA:
            begin
                if (!count_down && at_top)
                begin
                    next_dir   = 1'b1;
                    next_count = timer_count_value - 8'h01;
                end
                else if (count_down && timer_count_value == COUNT_BOTTOM)  // [R17]
                begin
                    next_dir   = 1'b0;
                    next_count = timer_count_value + 8'h01;
                    ovf_event  = 1'b1;  // [R19]
                end
                else
                    next_count = count_down ? timer_count_value - 8'h01
                                            : timer_count_value + 8'h01;
            end
            WM_FAST_OCRA, WM_CTC:
            begin
                // CLEAR_ON_COMPARE_MODE clears whenever the count equals compare A on a tick, even with the match blocked, never on a forced one
                next_count = at_top ? COUNT_BOTTOM : timer_count_value + 8'h01;  // [R2]
                ovf_event  = (wave_mode_field == WM_FAST_OCRA) ? at_top
                             : (timer_count_value == COUNT_MAX);  // [R19]
            end
            default:
            begin
                next_count = timer_count_value + 8'h01;  // [R21]
                ovf_event  = (timer_count_value == COUNT_MAX);  // [R13] [R21]
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            timer_count_value <= RESET_BYTE;  // [R8]
            count_down        <= 1'b0;
        end
        else if (wr_count)
            timer_count_value <= wbyte;  // [R8]
        else if (tick)
        begin
            timer_count_value <= next_count;
            count_down        <= next_dir;
        end
    end

    // Write to counter blocks the match on the next tick
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            block_match <= 1'b0;
        else if (wr_count)
            block_match <= 1'b1;  // [R9]
        else if (tick)
            block_match <= 1'b0;
    end

    // Hardware set wins over software or vector clear
    assign flag_set[IRQ_BIT_CMP_B] = match_b;  // [R12]
    assign flag_set[IRQ_BIT_CMP_A] = match_a;  // [R12]
    assign flag_set[IRQ_BIT_OVF]   = tick && ovf_event;  // [R13]
    assign flag_wr_clr = (wr_pend && wr_idx == IDX_IRQ_FLAGS) ? wbyte[2:0] : 3'b000;  // [R15]
    assign flag_clr    = vector_ack | flag_wr_clr;  // [R14]

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            timer_irq_flags <= 3'b000;
        else
            timer_irq_flags <= flag_set | (timer_irq_flags & ~flag_clr);
    end

    assign irq_request = timer_irq_flags & timer_irq_enable & {3{global_irq_enable}};  // [R11]

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            compare_out_pin_a <= 1'b0;
            compare_out_pin_b <= 1'b0;
        end
        else
        begin
            if ((match_a && !pwm_mode) || force_a)  // [R20] [R1] [R2]
            begin
                case (compare_out_mode_a)
                    2'b01:   compare_out_pin_a <= !compare_out_pin_a;
                    2'b10:   compare_out_pin_a <= 1'b0;
                    2'b11:   compare_out_pin_a <= 1'b1;
                    default: compare_out_pin_a <= compare_out_pin_a;
                endcase
            end
            if ((match_b && !pwm_mode) || force_b)  // [R20] [R1]
            begin
                case (compare_out_mode_b)
                    2'b01:   compare_out_pin_b <= !compare_out_pin_b;
                    2'b10:   compare_out_pin_b <= 1'b0;
                    2'b11:   compare_out_pin_b <= 1'b1;
                    default: compare_out_pin_b <= compare_out_pin_b;
                endcase
            end
        end
    end

    a_force_no_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        (force_a && !match_a && !vector_ack[1]) |=> $stable(timer_irq_flags[1]))  // [R2]
        else $error("forced compare changed flag");
    a_ctrl_b_read: assert property (@(posedge hclk) disable iff (!hresetn)
        bus_rd && bus_idx == IDX_CTRL_B |=> hrdata[7:4] == 4'h0)  // [R3]
        else $error("control b upper bits not zero");
    a_count_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_count |=> timer_count_value == $past(wbyte))  // [R8]
        else $error("counter write lost");
    a_stop_holds: assert property (@(posedge hclk) disable iff (!hresetn)
        clock_source_select == CLK_STOP && !wr_count |=> $stable(timer_count_value))  // [R5]
        else $error("stopped counter moved");
    a_match_block: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_count ##1 (tick && !wr_count) |-> !match_a && !match_b)  // [R9]
        else $error("match after counter write");
    a_irq_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        irq_request[0] |-> timer_irq_flags[0] && timer_irq_enable[0] && global_irq_enable)  // [R11]
        else $error("overflow request not gated");
    a_flag_set_b: assert property (@(posedge hclk) disable iff (!hresetn)
        match_b |=> timer_irq_flags[2])  // [R12]
        else $error("compare b flag not set");
    a_normal_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
        tick && !wr_count && wave_mode_field == WM_NORMAL && timer_count_value == COUNT_MAX
        |=> timer_count_value == COUNT_BOTTOM && timer_irq_flags[0])  // [R21]
        else $error("normal mode wrap wrong");
    a_w1c_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pend && wr_idx == IDX_IRQ_FLAGS && wbyte[1] && !match_a |=> !timer_irq_flags[1])  // [R15]
        else $error("flag write one did not clear");
endmodule // ebt_timer

/* test/eight_bit_timer_control_and_flags_tb_top.sv */
`timescale 1ns/1ps
module eight_bit_timer_control_and_flags_tb_top
    import ebt_pkg::*;
;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        ext_pin;
    logic        glob_en;
    logic [2:0]  vec_ack;
    logic        pin_a;
    logic        pin_b;
    logic        en_a;
    logic        en_b;
    logic [2:0]  irq_req;
    logic [7:0]  rd;
    int          n_mismatch;
    int          check_count;
    int          cyc;

    ebt_timer dut (
        .hclk               (hclk),
        .hresetn            (hresetn),
        .hsel               (hsel),
        .haddr              (haddr),
        .htrans             (htrans),
        .hwrite             (hwrite),
        .hsize              (hsize),
        .hwdata             (hwdata),
        .hready             (hreadyout),
        .hrdata             (hrdata),
        .hreadyout          (hreadyout),
        .hresp              (hresp),
        .external_count_pin (ext_pin),
        .global_irq_enable  (glob_en),
        .vector_ack         (vec_ack),
        .compare_out_pin_a  (pin_a),
        .compare_out_pin_b  (pin_b),
        .compare_out_en_a   (en_a),
        .compare_out_en_b   (en_b),
        .irq_request        (irq_req)
    );

    always #25 hclk = ~hclk;

    task automatic test_done();
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Run is about 12k cycles
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
        check_count++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                        output logic [7:0] rdat);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdat = hrdata[7:0];
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] dummy;
        xfer(1'b1, idx, d, dummy);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] v;
        xfer(1'b0, idx, 8'h00, v);
        chk(v, exp);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic do_reset();
        hresetn <= 1'b0;
        wait_cyc(6);
        hresetn <= 1'b1;
    endtask

    // Load counter, run undivided for n cycles, stop
    task automatic run_div1(input logic [7:0] start, input int n);
        wr(IDX_COUNT, start);
        wr(IDX_CTRL_B, 8'h01);
        wait_cyc(n);
        wr(IDX_CTRL_B, 8'h00);
    endtask

    task automatic t_regs();
        logic [7:0] tab [6] = '{IDX_CTRL_B, IDX_COUNT, IDX_CMP_A, IDX_CMP_B,
                                IDX_IRQ_ENABLE, IDX_IRQ_FLAGS};
        foreach (tab[i]) rd_chk(tab[i], 8'h00);
        chk({7'h00, hresp}, 8'h00);
        wr(IDX_CTRL_B, 8'hF0);
        rd_chk(IDX_CTRL_B, 8'h00);
        wr(IDX_IRQ_ENABLE, 8'hFF);
        rd_chk(IDX_IRQ_ENABLE, 8'h07);
        wr(IDX_IRQ_FLAGS, 8'hFF);
        rd_chk(IDX_IRQ_FLAGS, 8'h00);
        wr(IDX_COUNT, 8'hA5);
        rd_chk(IDX_COUNT, 8'hA5);
        wr(IDX_CMP_A, 8'h5A);
        rd_chk(IDX_CMP_A, 8'h5A);
        wr(IDX_CMP_B, 8'hC3);
        rd_chk(IDX_CMP_B, 8'hC3);
        wr(8'h3F, 8'hFF);
        rd_chk(8'h3F, 8'h00);
    endtask

    task automatic t_compare();
        wr(IDX_CMP_A, 8'h08);
        wr(IDX_CMP_B, 8'h0C);
        wr(IDX_CTRL_A, 8'h70);
        wr(IDX_IRQ_FLAGS, 8'h07);
        run_div1(8'h00, 30);
        rd_chk(IDX_IRQ_FLAGS, 8'h06);
        chk({6'h0, pin_a, pin_b}, 8'h03);
        chk({6'h0, en_a, en_b}, 8'h03);
        wr(IDX_IRQ_ENABLE, 8'h06);
        glob_en <= 1'b1;
        wait_cyc(1);
        chk({5'h0, irq_req}, 8'h06);
        glob_en <= 1'b0;
        wait_cyc(1);
        chk({5'h0, irq_req}, 8'h00);
        wr(IDX_IRQ_ENABLE, 8'h02);
        glob_en <= 1'b1;
        wait_cyc(1);
        chk({5'h0, irq_req}, 8'h02);
    endtask

    task automatic t_overflow();
        wr(IDX_CMP_A, 8'h80);
        wr(IDX_CMP_B, 8'h80);
        wr(IDX_IRQ_FLAGS, 8'h07);
        wr(IDX_IRQ_ENABLE, 8'h01);
        run_div1(8'hF0, 30);
        rd_chk(IDX_IRQ_FLAGS, 8'h01);
        chk({5'h0, irq_req}, 8'h01);
        xfer(1'b0, IDX_COUNT, 8'h00, rd);
        chk_rng(rd, 8'h08, 8'h20);
        vec_ack <= 3'b001;
        @(posedge hclk);
        vec_ack <= 3'b000;
        rd_chk(IDX_IRQ_FLAGS, 8'h00);
        run_div1(8'hFE, 5);
        wr(IDX_IRQ_FLAGS, 8'h06);
        rd_chk(IDX_IRQ_FLAGS, 8'h01);
        wr(IDX_IRQ_FLAGS, 8'h01);
        rd_chk(IDX_IRQ_FLAGS, 8'h00);
    endtask

    task automatic t_suppress();
        wr(IDX_CMP_B, 8'h40);
        run_div1(8'h3C, 10);
        rd_chk(IDX_IRQ_FLAGS, 8'h04);
        wr(IDX_IRQ_FLAGS, 8'h07);
        wr(IDX_CTRL_B, 8'h01);
        wr(IDX_COUNT, 8'h40);
        wait_cyc(3);
        wr(IDX_CTRL_B, 8'h00);
        rd_chk(IDX_IRQ_FLAGS, 8'h00);
    endtask

    task automatic t_prescale();
        int div_tab [5] = '{1, 8, 64, 256, 1024};
        foreach (div_tab[i])
        begin
            wr(IDX_COUNT, 8'h00);
            wr(IDX_CTRL_B, 8'(i + 1));
            wait_cyc(8 * div_tab[i]);
            wr(IDX_CTRL_B, 8'h00);
            xfer(1'b0, IDX_COUNT, 8'h00, rd);
            chk_rng(rd, 8'h08, 8'h0D);
            wait_cyc(50);
            rd_chk(IDX_COUNT, rd);
        end
    endtask

    task automatic t_external();
        for (int sel = 6; sel <= 7; sel++)
        begin
            wr(IDX_COUNT, 8'h00);
            wr(IDX_CTRL_B, 8'(sel));
            repeat (3)
            begin
                ext_pin <= 1'b0;
                wait_cyc(5);
                ext_pin <= 1'b1;
                wait_cyc(5);
            end
            wr(IDX_CTRL_B, 8'h00);
            rd_chk(IDX_COUNT, 8'h03);
        end
    endtask

    task automatic t_force();
        logic [1:0] mode_tab [4] = '{2'b11, 2'b10, 2'b01, 2'b01};
        logic       pin_tab  [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        wr(IDX_CMP_A, 8'h33);
        wr(IDX_COUNT, 8'h33);
        wr(IDX_IRQ_FLAGS, 8'h07);
        foreach (mode_tab[i])
        begin
            wr(IDX_CTRL_A, {mode_tab[i], mode_tab[i], 4'h2});
            wr(IDX_CTRL_B, 8'hC0);
            wait_cyc(2);
            chk({6'h0, pin_a, pin_b}, {6'h0, pin_tab[i], pin_tab[i]});
        end
        rd_chk(IDX_IRQ_FLAGS, 8'h00);
        rd_chk(IDX_COUNT, 8'h33);
        wr(IDX_CTRL_A, 8'hF3);
        wr(IDX_CTRL_B, 8'hC0);
        wait_cyc(2);
        chk({6'h0, pin_a, pin_b}, 8'h00);
        wr(IDX_CTRL_B, 8'h00);
        wr(IDX_CTRL_A, 8'h03);
        wait_cyc(1);
        chk({6'h0, en_a, en_b}, 8'h00);
    endtask

    // Phase-correct turn at top, bottom overflow, then top from compare A
    task automatic t_modes();
        wr(IDX_IRQ_FLAGS, 8'h07);
        wr(IDX_CTRL_A, 8'h01);
        run_div1(8'hFD, 30);
        xfer(1'b0, IDX_COUNT, 8'h00, rd);
        chk_rng(rd, 8'hD8, 8'hE8);
        rd_chk(IDX_IRQ_FLAGS, 8'h00);
        run_div1(8'h05, 30);
        xfer(1'b0, IDX_COUNT, 8'h00, rd);
        chk_rng(rd, 8'h18, 8'h20);
        rd_chk(IDX_IRQ_FLAGS, 8'h01);
        wr(IDX_IRQ_FLAGS, 8'h07);
        wr(IDX_CTRL_A, 8'h03);
        wr(IDX_COUNT, 8'h30);
        wr(IDX_CTRL_B, 8'h09);
        wait_cyc(30);
        wr(IDX_CTRL_B, 8'h08);
        xfer(1'b0, IDX_COUNT, 8'h00, rd);
        chk_rng(rd, 8'h18, 8'h22);
        rd_chk(IDX_IRQ_FLAGS, 8'h03);
    endtask

    initial
    begin
        hclk        = 1'b0;
        hresetn     = 1'b0;
        hsel        = 1'b0;
        haddr       = 32'h0000_0000;
        htrans      = 2'b00;
        hwrite      = 1'b0;
        hsize       = 3'b010;
        hwdata      = 32'h0000_0000;
        ext_pin     = 1'b1;
        glob_en     = 1'b0;
        vec_ack     = 3'b000;
        n_mismatch  = 0;
        check_count = 0;
        cyc         = 0;
        do_reset();
        t_regs();
        t_compare();
        t_overflow();
        t_suppress();
        t_prescale();
        t_external();
        t_force();
        t_modes();
        wr(IDX_COUNT, 8'h77);
        do_reset();
        rd_chk(IDX_COUNT, 8'h00);
        test_done();
    end
endmodule // eight_bit_timer_control_and_flags_tb_top
